// file: hdl/purs_pkg.sv
package purs_pkg;
  // Clock rate and timing figures
  localparam int CLK_HZ = 20_000_000;
  localparam int EN_DLY_MS = 11;
  localparam int MON_WAIT_MS = 10;
  localparam int RST_DLY_MS = 10;
  localparam int PARK_MAX_MS = 1;
  localparam int GLITCH_MIN_US = 20;
  localparam int GLITCH_MAX_US = 1000;
  localparam int EN_DLY_CYC = EN_DLY_MS * (CLK_HZ / 1000);
  localparam int MON_WAIT_CYC = MON_WAIT_MS * (CLK_HZ / 1000);
  localparam int RST_DLY_CYC = RST_DLY_MS * (CLK_HZ / 1000);
  localparam int PARK_CYC = 2;
  localparam int GLITCH_CYC = (GLITCH_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int GLITCH_MAX_CYC = GLITCH_MAX_US * (CLK_HZ / 1000) / 1000;
  localparam int FLT_CNT_W = 16;
  localparam int SEQ_CNT_W = 18;
  localparam int NUM_RAILS = 3;

  typedef enum logic [2:0] {
    PURS_IDLE   = 3'b000,
    PURS_EN_DLY = 3'b001,
    PURS_MON1   = 3'b011,
    PURS_MON2   = 3'b010,
    PURS_MON3   = 3'b110,
    PURS_RST_DLY = 3'b111,
    PURS_ON     = 3'b101,
    PURS_FAIL   = 3'b100
  } purs_state_e;

  typedef struct packed {
    logic io;
    logic mid;
    logic core;
  } purs_rails_s;
endpackage

// file: hdl/purs_uv_filter.sv
// Falling-only undervoltage filter for one monitor comparator
module purs_uv_filter #(
  parameter int FILT_CYC = purs_pkg::GLITCH_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Monitor level in, filtered level out
  input wire logic good_in,
  output logic good_out
);
  import purs_pkg::*;

  // Hold check needs at least two cycles of filtering
  if (FILT_CYC < 2 || FILT_CYC > GLITCH_MAX_CYC)
  begin : g_bad_filt
    $error("purs_uv_filter: FILT_CYC out of range");
  end

  logic [FLT_CNT_W-1:0] low_cnt;

  // Rising crossing passes at once; a fall must persist FILT_CYC cycles
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      low_cnt <= '0;
      good_out <= 1'b0;
    end
    else if (good_in)
    begin
      low_cnt <= '0;
      good_out <= 1'b1;
    end
    else if (low_cnt >= FLT_CNT_W'(FILT_CYC - 1))
      good_out <= 1'b0;
    else
      low_cnt <= low_cnt + FLT_CNT_W'(1);
  end

  property p_glitch_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(good_in) && good_out |-> good_out [*2];
  endproperty
  a_glitch_hold: assert property (p_glitch_hold)
    else $error("short monitor glitch dropped good");

  property p_fault_seen;
    @(posedge clk_in) disable iff (!rst_n_in)
    !good_in [*8] |-> ##[0:1000] !good_out || good_in;
  endproperty
  a_fault_seen: assert property (p_fault_seen)
    else $error("persisting undervoltage not reported");
endmodule // purs_uv_filter

// file: hdl/purs_sequencer.sv
// Contract
// - Core rail enable rises 11 ms after power request rises, synchronization included.
// - 10 ms after core enable, sample core monitor for threshold.
// - 10 ms after mid enable, sample mid monitor as pass/fail.
// - 10 ms after io enable, sample io monitor as pass/fail.
// - Every rail wait runs full length even on early success.
// - Release system reset 10 ms after io test passes.
// - Failed test keeps reset asserted; restart from the beginning needed.
// - Monitors act on falls; short glitches ignored, long ones are faults. Code faults them only in PURS_ON or at the rail's own sample point.
// - Falling power request drives mirror park low within 1 ms.
module purs_sequencer #(
  parameter int EN_CYC = purs_pkg::EN_DLY_CYC,
  parameter int MON_CYC = purs_pkg::MON_WAIT_CYC,
  parameter int RST_CYC = purs_pkg::RST_DLY_CYC,
  parameter int FILT_CYC = purs_pkg::GLITCH_CYC
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  // Host request and supply monitors
  input wire logic POWER_REQUEST_IN,
  input wire purs_pkg::purs_rails_s RAIL_GOOD_IN,
  // Rail enables, reset and park
  output purs_pkg::purs_rails_s RAIL_ENABLE_OUT,
  output logic SYSTEM_RESET_N_OUT,
  output logic MIRROR_PARK_N_OUT,
  output logic SEQ_FAULT_OUT
);
  import purs_pkg::*;

  // Enable delay compare point is EN_CYC - 3, so three cycles at least
  if (EN_CYC < 3 || MON_CYC < 1 || RST_CYC < 1 ||
      EN_CYC >= 2 ** SEQ_CNT_W || MON_CYC >= 2 ** SEQ_CNT_W ||
      RST_CYC >= 2 ** SEQ_CNT_W)
  begin : g_bad_timing
    $error("purs_sequencer: timing parameter out of range");
  end

  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] req_sync;
  logic [1:0] good_sync [NUM_RAILS];
  logic [NUM_RAILS-1:0] good_flt;
  logic req;
  logic [SEQ_CNT_W-1:0] cnt;
  logic cnt_done;
  purs_state_e state;
  purs_state_e next_state;

  // Reset release through two flops
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      req_sync <= 2'h0;
    else
      req_sync <= {req_sync[0], POWER_REQUEST_IN};
  end
  assign req = req_sync[1];

  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g++)
    begin : g_mon
      always_ff @(posedge MCLK_IN or negedge rst_n)
      begin
        if (!rst_n)
          good_sync[g] <= 2'h0;
        else
          good_sync[g] <= {good_sync[g][0], RAIL_GOOD_IN[g]};
      end
      purs_uv_filter #(
        .FILT_CYC(FILT_CYC)
      ) purs_uv_filter_i (
        .clk_in(MCLK_IN),
        .rst_n_in(rst_n),
        .good_in(good_sync[g][1]),
        .good_out(good_flt[g])
      );
    end
  endgenerate

  always_comb
  begin
    case (state)
      PURS_EN_DLY: cnt_done = (cnt == SEQ_CNT_W'(EN_CYC - 3));
      PURS_MON1, PURS_MON2, PURS_MON3:
        cnt_done = (cnt == SEQ_CNT_W'(MON_CYC - 1));
      PURS_RST_DLY: cnt_done = (cnt == SEQ_CNT_W'(RST_CYC - 1));
      default: cnt_done = 1'b0;
    endcase
  end

  // Shared delay counter, cleared at each step and while request is low
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (!req || cnt_done || state != next_state)
      cnt <= '0;
    else
      cnt <= cnt + SEQ_CNT_W'(1);
  end

  always_comb
  begin
    next_state = state;
    case (state)
      PURS_IDLE: if (req) next_state = PURS_EN_DLY;
      PURS_EN_DLY: if (cnt_done) next_state = PURS_MON1;
      PURS_MON1: if (cnt_done)
        next_state = good_flt[0] ? PURS_MON2 : PURS_FAIL;
      PURS_MON2: if (cnt_done)
        next_state = good_flt[1] ? PURS_MON3 : PURS_FAIL;
      PURS_MON3: if (cnt_done)
        next_state = good_flt[2] ? PURS_RST_DLY : PURS_FAIL;
      PURS_RST_DLY: if (cnt_done) next_state = PURS_ON;
      PURS_ON: if (good_flt != 3'h7) next_state = PURS_FAIL;
      PURS_FAIL: next_state = PURS_FAIL;
      default: next_state = PURS_IDLE;
    endcase
    if (!req)
      next_state = PURS_IDLE;
  end

  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      state <= PURS_IDLE;
    else
      state <= next_state;
  end

  // Outputs registered from next state
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      RAIL_ENABLE_OUT <= '0;
      SYSTEM_RESET_N_OUT <= 1'b0;
      SEQ_FAULT_OUT <= 1'b0;
    end
    else
    begin
      RAIL_ENABLE_OUT.core <= next_state inside {PURS_MON1, PURS_MON2,
        PURS_MON3, PURS_RST_DLY, PURS_ON};
      RAIL_ENABLE_OUT.mid <= next_state inside {PURS_MON2, PURS_MON3,
        PURS_RST_DLY, PURS_ON};
      RAIL_ENABLE_OUT.io <= next_state inside {PURS_MON3, PURS_RST_DLY,
        PURS_ON};
      SYSTEM_RESET_N_OUT <= (next_state == PURS_ON);
      SEQ_FAULT_OUT <= (next_state == PURS_FAIL);
    end
  end

  // Park goes low as soon as the request is gone
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      MIRROR_PARK_N_OUT <= 1'b0;
    else
      MIRROR_PARK_N_OUT <= req;
  end

  property p_en_delay;
    @(posedge MCLK_IN) disable iff (!rst_n)
    $rose(state == PURS_EN_DLY) |-> !RAIL_ENABLE_OUT.core [*8];
  endproperty
  a_en_delay: assert property (p_en_delay)
    else $error("core enable rose too early");

  property p_mon_full;
    @(posedge MCLK_IN) disable iff (!rst_n)
    $rose(RAIL_ENABLE_OUT.core) |-> !RAIL_ENABLE_OUT.mid [*8];
  endproperty
  a_mon_full: assert property (p_mon_full)
    else $error("core wait cut short");

  property p_mid_wait;
    @(posedge MCLK_IN) disable iff (!rst_n)
    $rose(RAIL_ENABLE_OUT.mid) |-> !RAIL_ENABLE_OUT.io [*8];
  endproperty
  a_mid_wait: assert property (p_mid_wait)
    else $error("mid wait cut short");

  property p_io_wait;
    @(posedge MCLK_IN) disable iff (!rst_n)
    $rose(RAIL_ENABLE_OUT.io) |-> !SYSTEM_RESET_N_OUT [*8];
  endproperty
  a_io_wait: assert property (p_io_wait)
    else $error("io wait cut short");

  property p_rst_dly;
    @(posedge MCLK_IN) disable iff (!rst_n)
    $rose(state == PURS_RST_DLY) |-> !SYSTEM_RESET_N_OUT [*8];
  endproperty
  a_rst_dly: assert property (p_rst_dly)
    else $error("reset released early");

  property p_fail_hold;
    @(posedge MCLK_IN) disable iff (!rst_n)
    state == PURS_FAIL |=> !SYSTEM_RESET_N_OUT;
  endproperty
  a_fail_hold: assert property (p_fail_hold)
    else $error("reset released after failed test");

  property p_order;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (RAIL_ENABLE_OUT.io |-> RAIL_ENABLE_OUT.mid) and
    (RAIL_ENABLE_OUT.mid |-> RAIL_ENABLE_OUT.core);
  endproperty
  a_order: assert property (p_order)
    else $error("rail enable order broken");

  property p_park;
    @(posedge MCLK_IN) disable iff (!rst_n)
    $fell(POWER_REQUEST_IN) |-> ##[1:4] !MIRROR_PARK_N_OUT;
  endproperty
  a_park: assert property (p_park)
    else $error("park not driven low after request fell");

  property p_cnt_clear;
    @(posedge MCLK_IN) disable iff (!rst_n)
    !req |=> cnt == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("delay counter not cleared");

  c_power_on: cover property (@(posedge MCLK_IN) $rose(SYSTEM_RESET_N_OUT));
  c_fail: cover property (@(posedge MCLK_IN) $rose(SEQ_FAULT_OUT));
  c_park: cover property (@(posedge MCLK_IN) $fell(MIRROR_PARK_N_OUT));
endmodule // purs_sequencer

// file: dv/purs_rail_model.sv
// Regulators and monitor comparators on the far side of the sequencer
module purs_rail_model (
  // Clock
  input wire logic clk_in,
  // Enables and bench controls
  input wire purs_pkg::purs_rails_s enable_in,
  input wire purs_pkg::purs_rails_s fail_in,
  input wire purs_pkg::purs_rails_s drop_in,
  input wire logic early_in,
  input wire logic shared_in,
  input wire logic [7:0] ramp_in,
  // Monitor comparators
  output purs_pkg::purs_rails_s good_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import purs_pkg::*;
  logic [7:0] ramp [3];
  logic [2:0] en;
  logic [2:0] up;
  // Shared mode: all three regulators hang on the core enable
  assign en = shared_in ? {3{enable_in.core}} :
    {enable_in.io, enable_in.mid, enable_in.core};
  // Cycles since each enable rose
  always_ff @(posedge clk_in)
  begin
    for (int i = 0; i < 3; i++)
      ramp[i] <= en[i] ? ramp[i] + {7'h00, ramp[i] != 8'hFF} : 8'h00;
  end
  // Rail is good after its ramp, or already powered by outside logic
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      up[i] = early_in | (en[i] & (ramp[i] >= ramp_in));
  end
  assign good_out = up & ~fail_in & ~drop_in;
endmodule // purs_rail_model

// file: dv/purs_sequencer_tb.sv
module purs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import purs_pkg::*;
  localparam int EN = 40, MC = 20, RC = 20, FC = 4;
  logic clk = 1'b0, arst_n = 1'b0, req = 1'b0, early = 1'b0;
  logic shared = 1'b0;
  logic [2:0] exp_ev;
  int exp_cyc;
  purs_rails_s en, good, fail = '0, drop = '0;
  logic rst_n, park_n, fault;
  logic [7:0] ramp = 8'h00;
  logic [5:0] prev = 6'h10, now;
  int cyc = 0, err_total = 0, compares = 0;
  logic [2:0] ev_q[$];
  int cyc_q[$];

  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  purs_sequencer #(.EN_CYC(EN), .MON_CYC(MC), .RST_CYC(RC), .FILT_CYC(FC))
    purs_sequencer_i (.MCLK_IN(clk), .ARST_N_IN(arst_n),
    .POWER_REQUEST_IN(req), .RAIL_GOOD_IN(good), .RAIL_ENABLE_OUT(en),
    .SYSTEM_RESET_N_OUT(rst_n), .MIRROR_PARK_N_OUT(park_n),
    .SEQ_FAULT_OUT(fault));
  purs_rail_model purs_rail_model_i (.clk_in(clk), .enable_in(en),
    .fail_in(fail), .drop_in(drop), .early_in(early),
    .shared_in(shared), .ramp_in(ramp),
    .good_out(good));

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_event(input logic [2:0] xe, ge, input int xc, gc);
    compares++;
    if (xe !== ge || gc < xc - 2 || gc > xc + 2)
    begin
      err_total++;
      $display("wrong value event: expected %0d@%0d, seen %0d@%0d",
        xe, xc, ge, gc);
    end
  endtask

  task automatic check_level(input string name, input logic x, g);
    compares++;
    if (x !== g)
    begin
      err_total++;
      $display("wrong value %s: expected %b, seen %b", name, x, g);
    end
  endtask

  task automatic note(input logic [2:0] ev, input int c);
    ev_q.push_back(ev);
    cyc_q.push_back(c);
  endtask

  task automatic drain();
    for (int k = 0; k < 400 && ev_q.size() > 0; k++)
      @(posedge clk);
    if (ev_q.size() > 0)
    begin
      err_total++;
      $display("wrong value pending: expected 0, seen %0d", ev_q.size());
      stop_test();
    end
  endtask

  // Raise request; fail_at 3 means all rails pass
  task automatic power_up(input int fail_at);
    int n;
    @(negedge clk);
    req = 1'b1;
    n = cyc + 1;
    for (int i = 0; i <= fail_at && i < 3; i++)
      note(3'(i), n + EN + i * MC);
    if (fail_at > 2)
      note(3'd3, n + EN + 3 * MC + RC);
    else
      note(3'd5, n + EN + (fail_at + 1) * MC);
  endtask

  task automatic power_down();
    @(negedge clk);
    req = 1'b0;
    note(3'd4, cyc + 3);
  endtask

  // Rising edges of core, mid, io, reset release, park, fault
  always @(posedge clk)
  begin
    #1;
    now = {fault, ~park_n, rst_n, en.io, en.mid, en.core};
    for (int i = 0; i < 6; i++)
      if (arst_n && now[i] === 1'b1 && prev[i] === 1'b0)
      begin
        exp_ev = ev_q.size() > 0 ? ev_q.pop_front() : 3'd7;
        exp_cyc = cyc_q.size() > 0 ? cyc_q.pop_front() : 0;
        check_event(exp_ev, 3'(i), exp_cyc, cyc);
      end
    prev = now;
  end

  initial
  begin
    void'($urandom(32'h38AE));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk);
      ramp = 8'($urandom_range(15));
      shared = (k == 1);
      power_up(3);
      drain();
      power_down();
      drain();
    end
    shared = 1'b0;
    early = 1'b1;
    power_up(3);
    drain();
    @(negedge clk);
    drop.core = 1'b1;
    repeat (FC - 2) @(negedge clk);
    drop = '0;
    repeat (12) @(negedge clk);
    check_level("reset_n", 1'b1, rst_n);
    drop.mid = 1'b1;
    note(3'd5, cyc + 1 + FC + 2);
    repeat (FC + 8) @(negedge clk);
    drop = '0;
    drain();
    check_level("reset_n", 1'b0, rst_n);
    check_level("rail_enable", 1'b0, en.core | en.mid | en.io);
    power_down();
    drain();
    early = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk);
      fail = 3'(1 << k);
      ramp = 8'($urandom_range(15));
      power_up(k);
      drain();
      repeat (30) @(negedge clk);
      check_level("reset_n", 1'b0, rst_n);
      power_down();
      drain();
      fail = '0;
    end
    power_up(3);
    ev_q.delete();
    cyc_q.delete();
    repeat (EN - 10) @(negedge clk);
    power_down();
    drain();
    power_up(3);
    drain();
    stop_test();
  end
endmodule // purs_sequencer_tb
